/* verilog/iars_params.svh */
// constants for the interrupt accept/return sequencer
// assumes one machine-cycle enable drives the sequence
`ifndef IARS_PARAMS_SVH
`define IARS_PARAMS_SVH
`define IARS_NSRC 16
`define IARS_ACCEPT_CYCLES 8
`define IARS_STACK_BYTES 3
`define IARS_SWI_OPCODE 8'hff
`define IARS_FETCH_FILL 8'hff
`define IARS_MAX_LAT_FC 38
`define IARS_VEC_BASE 16'hffe0
`define IARS_VEC_SWI 16'hfffc
`define IARS_VEC_UNDEF 16'hfffc
`define IARS_VEC_ATRAP 16'hfffa
`define IARS_VEC_WDT 16'hfff8
`define IARS_SEL_WIDTH 5
`define IARS_SRC_NONE 5'h1f
`define IARS_SRC_SWI 5'h10
`define IARS_SRC_UNDEF 5'h11
`define IARS_IDX_ATRAP 2
`define IARS_IDX_WDT 3
`define IARS_REG_IMF 16'h0000
`define IARS_REG_EF 16'h0004
`define IARS_REG_IL 16'h0008
`define IARS_REG_STATE 16'h000c
`define IARS_REG_SP 16'h0010
`define IARS_REG_MEMMAP 16'h0014
`define IARS_SP_RESET 8'hff
`endif

/* verilog/iars_pkg.sv */
// types for the interrupt accept/return sequencer
// assumes iars_params.svh holds the shared constants; the state codes are fixed here
package iars_pkg;
  typedef enum logic [4:0] {
    IARS_IDLE = 5'b0_0001,
    IARS_ACCEPT = 5'b0_0010,
    IARS_VECTOR = 5'b0_0100,
    IARS_RETURN = 5'b0_1000,
    IARS_DONE = 5'b1_0000
  } iars_state_t;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } iars_stack_t;
endpackage

/* verilog/iars_sequencer.sv */
// interrupt accept/return sequencer with ahb-lite register slave
// assumes the core raises instr_last in the final cycle of each instruction
// Summary of operation
// - pending latches hold a request until accepted, reset or software clear.
// - acceptance takes eight machine cycles, started after current instruction ends.
// - routines end with maskable or nonmaskable return per source kind.
// - first acceptance step clears the master enable.
// - acceptance clears only the accepted source's pending latch.
// - push status, high pc, low pc; stack pointer drops by three.
// - after pushing, load pc from the source's vector slot.
// - latency from latch set to acceptance at most 38 fast clocks.
// - master enable zero blocks every maskable request.
// - only pc and status word saved by hardware.
// - either return restores pc and status, stack pointer up by three.
// - after acceptance low pc at sp+1, high pc at sp+2.
// - requests sampled in last instruction cycle, so accept right after return.
// - software-trap opcode starts highest-priority software interrupt immediately.
// - fetch from missing address returns ff, decoding as software trap.
// - fetch from data ram or register region raises address trap.
// - executing an undefined opcode raises the undefined-opcode interrupt.
// - undefined-opcode interrupt accepted even during nonmaskable service.
// - undefined-opcode interrupt jumps through its vector like the trap.
// - nonmaskable sources ignore master and per-source enables.
// - latches reset to zero and no instruction sets them.
`include "iars_params.svh"
module iars_sequencer
  import iars_pkg::*;
#(
  parameter int NSRC = `IARS_NSRC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic mc_en,
  input wire logic instr_last,
  input wire logic [7:0] opcode,
  input wire logic opcode_undefined,
  input wire logic [15:0] fetch_addr,
  input wire logic fetch_valid,
  input wire logic [15:0] pc_in,
  input wire logic [7:0] status_in,
  input wire logic ret_mask,
  input wire logic ret_nonmask,
  input wire logic [NSRC-1:0] irq_req,
  input wire logic [7:0] stack_rdata,
  output iars_stack_t stack,
  output logic [15:0] vec_addr,
  output logic vec_fetch,
  input wire logic [15:0] vec_data,
  output logic [15:0] pc_out,
  output logic pc_load,
  output logic [7:0] status_out,
  output logic status_load,
  output logic seq_busy,
  output logic atrap_reset,
  output logic [7:0] fetch_fill
);
  // ==========================================================
  // register slave
  logic ph_we, ph_re;
  logic [7:0] ph_addr;
  logic next_ph_we, next_ph_re;
  logic [7:0] next_ph_addr;
  logic master_irq_enable, next_imf;
  logic [NSRC-1:0] per_source_enable, next_ef;
  logic [NSRC-1:0] irq_pending_latch, next_il;
  logic [7:0] sp, next_sp;
  logic [15:0] ram_top, next_ram_top;
  logic atrap_as_irq, next_atrap_as_irq;
  logic [31:0] next_hrdata;
  logic sw_imf_wr, sw_ef_wr, sw_il_wr, sw_sp_wr, sw_map_wr;
  iars_state_t state, next_state;
  logic from_ret, next_from_ret;

  // zero wait states: reads are registered at the address-phase edge, writes take effect at the data-phase edge
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  always_comb begin
    next_ph_we = 1'b0;
    next_ph_re = 1'b0;
    next_ph_addr = ph_addr;
    if (hsel && hready && htrans[1]) begin
      next_ph_we = hwrite;
      next_ph_re = !hwrite;
      next_ph_addr = haddr[7:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_we <= 1'b0;
      ph_re <= 1'b0;
      ph_addr <= 8'h00;
    end else begin
      ph_we <= next_ph_we;
      ph_re <= next_ph_re;
      ph_addr <= next_ph_addr;
    end
  end

  // decode on the low address byte only; higher address bits alias
  assign sw_imf_wr = ph_we && ph_addr == 8'(`IARS_REG_IMF);
  assign sw_ef_wr = ph_we && ph_addr == 8'(`IARS_REG_EF);
  assign sw_il_wr = ph_we && ph_addr == 8'(`IARS_REG_IL);
  assign sw_sp_wr = ph_we && ph_addr == 8'(`IARS_REG_SP);
  assign sw_map_wr = ph_we && ph_addr == 8'(`IARS_REG_MEMMAP);

  // read data registered in the address phase; unmapped reads give zero
  always_comb begin
    next_hrdata = hrdata;
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        8'(`IARS_REG_IMF): next_hrdata = {31'h0000_0000, master_irq_enable};
        8'(`IARS_REG_EF): next_hrdata = 32'(per_source_enable);
        8'(`IARS_REG_IL): next_hrdata = 32'(irq_pending_latch);
        8'(`IARS_REG_STATE): next_hrdata = {27'h000_0000, state};
        8'(`IARS_REG_SP): next_hrdata = {24'h00_0000, sp};
        8'(`IARS_REG_MEMMAP): next_hrdata = {15'h0000, atrap_as_irq, ram_top};
        default: next_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h0000_0000;
    else hrdata <= next_hrdata;
  end

  // ==========================================================
  // source selection
  logic [`IARS_SEL_WIDTH-1:0] sel, next_sel, pick;
  logic [3:0] cnt, next_cnt;
  logic [15:0] ret_pc, next_ret_pc;
  logic [7:0] ret_status, next_ret_status;
  logic ret_nmi_kind, next_ret_nmi_kind;
  logic in_nmi, next_in_nmi;
  logic [NSRC-1:0] nmi_mask, eligible;
  logic swi_hit, undef_hit, trap_fetch;
  logic accept_now;

  always_comb begin
    nmi_mask = '0;
    // trap mode only picks reset or latch; a set trap latch is never masked
    nmi_mask[`IARS_IDX_ATRAP] = 1'b1;
    nmi_mask[`IARS_IDX_WDT] = 1'b1;
  end

  assign eligible = irq_pending_latch &
      (nmi_mask | (per_source_enable & {NSRC{master_irq_enable}}));
  assign swi_hit = instr_last && opcode == `IARS_SWI_OPCODE;
  assign undef_hit = instr_last && opcode_undefined;
  assign trap_fetch = fetch_valid && fetch_addr < ram_top;
  assign atrap_reset = trap_fetch && !atrap_as_irq;
  // missing program space reads as the trap opcode
  assign fetch_fill = `IARS_FETCH_FILL;

  // software trap first, then undefined opcode, then lowest latch index
  always_comb begin
    pick = `IARS_SRC_NONE;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (eligible[i]) pick = i[`IARS_SEL_WIDTH-1:0];
    end
    if (undef_hit) pick = `IARS_SRC_UNDEF;
    if (swi_hit) pick = `IARS_SRC_SWI;
  end

  // undefined opcode breaks in even while nonmaskable work runs
  // sampled at every instruction end, so latency is bounded by one instruction
  assign accept_now = mc_en && instr_last && pick != `IARS_SRC_NONE &&
      (state == IARS_IDLE || (undef_hit && in_nmi));

  // ==========================================================
  // sequence
  always_comb begin
    next_state = state;
    next_sel = sel;
    next_cnt = cnt;
    next_imf = master_irq_enable;
    next_ef = per_source_enable;
    next_sp = sp;
    next_ret_pc = ret_pc;
    next_ret_status = ret_status;
    next_ret_nmi_kind = ret_nmi_kind;
    next_in_nmi = in_nmi;
    next_ram_top = ram_top;
    next_atrap_as_irq = atrap_as_irq;
    next_from_ret = from_ret;
    // latches only set by hardware; software can only clear
    next_il = irq_pending_latch | irq_req;
    if (sw_il_wr) next_il = (irq_pending_latch & hwdata[NSRC-1:0]) | irq_req;
    if (trap_fetch && atrap_as_irq) next_il[`IARS_IDX_ATRAP] = 1'b1;
    if (sw_imf_wr) next_imf = hwdata[0];
    if (sw_ef_wr) next_ef = hwdata[NSRC-1:0];
    if (sw_sp_wr) next_sp = hwdata[7:0];
    if (sw_map_wr) begin
      next_ram_top = hwdata[15:0];
      next_atrap_as_irq = hwdata[16];
    end
    stack = '0;
    vec_fetch = 1'b0;
    pc_load = 1'b0;
    status_load = 1'b0;
    case (state)
      IARS_IDLE: begin
        if (accept_now) begin
          next_state = IARS_ACCEPT;
          next_sel = pick;
          next_cnt = 4'h0;
          next_imf = 1'b0;
          next_ret_pc = pc_in;
          next_ret_status = {status_in[7:1], master_irq_enable};
          next_in_nmi = pick[4] || nmi_mask[pick[3:0]];
          next_from_ret = 1'b0;
          // a trap latch set in this very cycle survives the clear
          if (!pick[4]) next_il[pick[3:0]] = irq_req[pick[3:0]] ||
              (trap_fetch && atrap_as_irq && pick[3:0] == 4'(`IARS_IDX_ATRAP));
        end else if (mc_en && (ret_mask || ret_nonmask)) begin
          next_state = IARS_RETURN;
          next_from_ret = 1'b1;
          next_ret_nmi_kind = ret_nonmask;
          next_cnt = 4'h0;
        end
      end
      IARS_ACCEPT: begin
        if (mc_en) begin
          next_cnt = cnt + 4'h1;
          if (cnt < 4'(`IARS_STACK_BYTES)) begin
            stack.we = 1'b1;
            stack.addr = sp;
            next_sp = sp - 8'h01;
            case (cnt)
              4'h0: stack.wdata = ret_status;
              4'h1: stack.wdata = ret_pc[15:8];
              default: stack.wdata = ret_pc[7:0];
            endcase
          end
          if (cnt == 4'(`IARS_ACCEPT_CYCLES - 2)) next_state = IARS_VECTOR;
        end
      end
      IARS_VECTOR: begin
        vec_fetch = 1'b1;
        if (mc_en) begin
          pc_load = 1'b1;
          next_state = IARS_DONE;
        end
      end
      IARS_RETURN: begin
        if (mc_en) begin
          next_cnt = cnt + 4'h1;
          // pops mirror the pushes: low pc, high pc, then status
          stack.re = 1'b1;
          stack.addr = sp + 8'h01;
          next_sp = sp + 8'h01;
          case (cnt)
            4'h0: next_ret_pc[7:0] = stack_rdata;
            4'h1: next_ret_pc[15:8] = stack_rdata;
            default: begin
              next_ret_status = stack_rdata;
              next_imf = stack_rdata[0];
              next_state = IARS_DONE;
              if (ret_nmi_kind) next_in_nmi = 1'b0;
            end
          endcase
        end
      end
      IARS_DONE: begin
        // the return path hands the restored pc and status to the core here
        if (mc_en) begin
          next_state = IARS_IDLE;
          if (from_ret) begin
            pc_load = 1'b1;
            status_load = 1'b1;
          end
        end
      end
      default: next_state = IARS_IDLE;
    endcase
  end

  // maskable slots run downward from the top of the table
  always_comb begin
    case (sel)
      `IARS_SRC_SWI: vec_addr = `IARS_VEC_SWI;
      `IARS_SRC_UNDEF: vec_addr = `IARS_VEC_UNDEF;
      default: vec_addr = `IARS_VEC_BASE + 16'({~sel[3:0], 1'b0});
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= IARS_IDLE;
      sel <= `IARS_SRC_NONE;
      cnt <= 4'h0;
      master_irq_enable <= 1'b0;
      per_source_enable <= '0;
      irq_pending_latch <= '0;
      sp <= `IARS_SP_RESET;
      ret_pc <= 16'h0000;
      ret_status <= 8'h00;
      ret_nmi_kind <= 1'b0;
      in_nmi <= 1'b0;
      ram_top <= 16'h0000;
      atrap_as_irq <= 1'b0;
      from_ret <= 1'b0;
    end else begin
      state <= next_state;
      sel <= next_sel;
      cnt <= next_cnt;
      master_irq_enable <= next_imf;
      per_source_enable <= next_ef;
      irq_pending_latch <= next_il;
      sp <= next_sp;
      ret_pc <= next_ret_pc;
      ret_status <= next_ret_status;
      ret_nmi_kind <= next_ret_nmi_kind;
      in_nmi <= next_in_nmi;
      ram_top <= next_ram_top;
      atrap_as_irq <= next_atrap_as_irq;
      from_ret <= next_from_ret;
    end
  end

  // ==========================================================
  // core outputs
  // pc goes out as vector data on accept, stacked value on return
  assign pc_out = (state == IARS_VECTOR) ? vec_data : ret_pc;
  assign status_out = ret_status;
  assign seq_busy = state != IARS_IDLE;
endmodule // iars_sequencer

/* verif/iars_sequencer_properties.sv */
// port checker for the sequencer
// assumes it is bound to every iars_sequencer
// ====
// checker
module iars_seq_chk
  import iars_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic mc_en,
  input wire logic instr_last,
  input wire iars_stack_t stack,
  input wire logic [15:0] vec_addr,
  input wire logic vec_fetch,
  input wire logic pc_load,
  input wire logic seq_busy,
  input wire logic atrap_reset,
  input wire logic fetch_valid,
  input wire logic [7:0] fetch_fill
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [3:0] wr_cnt, next_wr_cnt, mc_cnt, next_mc_cnt;
  logic [7:0] last_a, next_last_a;
  // counts restart with each sequence
  always_comb begin
    next_wr_cnt = seq_busy ? wr_cnt + 4'(stack.we) : 4'h0;
    next_mc_cnt = seq_busy ? mc_cnt + 4'(mc_en) : 4'h0;
    next_last_a = stack.we ? stack.addr : last_a;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_cnt <= 4'h0;
      mc_cnt <= 4'h0;
      last_a <= 8'h00;
    end else begin
      wr_cnt <= next_wr_cnt;
      mc_cnt <= next_mc_cnt;
      last_a <= next_last_a;
    end
  end
  property p_push_three;
    pc_load && wr_cnt != 4'h0 |-> wr_cnt == 4'h3;
  endproperty
  a_push_three: assert property (p_push_three) else $error("push count");
  property p_accept_len;
    pc_load && wr_cnt != 4'h0 |-> mc_cnt == 4'h7;
  endproperty
  a_accept_len: assert property (p_accept_len) else $error("accept length");
  property p_push_down;
    stack.we && wr_cnt != 4'h0 |-> stack.addr == last_a - 8'h01;
  endproperty
  a_push_down: assert property (p_push_down) else $error("push address");
  property p_start;
    $rose(seq_busy) |-> $past(mc_en && instr_last);
  endproperty
  a_start: assert property (p_start) else $error("start point");
  property p_vec;
    vec_fetch |-> vec_addr[15:5] == 11'h7ff && !vec_addr[0];
  endproperty
  a_vec: assert property (p_vec) else $error("vector slot");
  property p_fill;
    fetch_fill == 8'hff;
  endproperty
  a_fill: assert property (p_fill) else $error("fetch fill");
  property p_trap;
    atrap_reset |-> fetch_valid;
  endproperty
  a_trap: assert property (p_trap) else $error("trap without fetch");
  property p_idle;
    !seq_busy |-> !stack.we && !vec_fetch;
  endproperty
  a_idle: assert property (p_idle) else $error("idle activity");
endmodule // iars_seq_chk
bind iars_sequencer iars_seq_chk u_chk (.hclk, .hresetn, .mc_en, .instr_last, .stack,
  .vec_addr, .vec_fetch, .pc_load, .seq_busy, .atrap_reset, .fetch_valid, .fetch_fill);

/* verif/iars_core_model.sv */
// stand-in for core stack ram and vector rom
// assumes stack reads answer in the same cycle
// ====
// model
module iars_core_model
  import iars_pkg::*;
(
  input wire logic hclk,
  input wire iars_stack_t stack,
  output logic [7:0] stack_rdata,
  input wire logic [15:0] vec_addr,
  input wire logic vec_fetch,
  output logic [15:0] vec_data,
  output logic mc_en
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [256];
  initial foreach (mem[i]) mem[i] = 8'h00;
  logic [1:0] div;
  initial div = 2'h0;
  always @(posedge hclk) div <= div + 2'h1;
  // four clocks to a machine cycle, so every step meets idle gaps
  assign mc_en = div == 2'h3;
  // unselected reads show the inverse, never stale data
  assign stack_rdata = stack.re ? mem[stack.addr] : ~mem[stack.addr];
  assign vec_data = vec_fetch ? {8'h80, vec_addr[7:0]} : {8'h7f, ~vec_addr[7:0]};
  always @(posedge hclk) if (stack.we) mem[stack.addr] <= stack.wdata;
endmodule // iars_core_model

/* verif/iars_sequencer_bench.sv */
// bench for the sequencer: bus tasks and directed sequences
// assumes entry address of a slot is 80 followed by slot low byte
// ====
// bench
module iars_sequencer_bench
  import iars_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, instr_last, opcode_undefined, fetch_valid;
  logic ret_mask, ret_nonmask, hreadyout, hresp, mc_en, vec_fetch, pc_load;
  logic status_load, seq_busy, atrap_reset;
  logic [31:0] haddr, hwdata, hrdata, rd, seen, last_pc, last_vec, last_st;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] opcode, status_in, stack_rdata, status_out, fetch_fill;
  logic [15:0] fetch_addr, pc_in, vec_addr, vec_data, pc_out, irq_req;
  iars_stack_t stack;
  int n_mismatch, check_count, cyc;
  iars_sequencer uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .mc_en, .instr_last,
    .opcode, .opcode_undefined, .fetch_addr, .fetch_valid, .pc_in, .status_in,
    .ret_mask, .ret_nonmask, .irq_req, .stack_rdata, .stack, .vec_addr, .vec_fetch,
    .vec_data, .pc_out, .pc_load, .status_out, .status_load, .seq_busy, .atrap_reset,
    .fetch_fill);
  iars_core_model mdl (.hclk, .stack, .stack_rdata, .vec_addr, .vec_fetch, .vec_data,
    .mc_en);
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    if (pc_load === 1'b1) last_pc <= {16'h0000, pc_out};
    if (vec_fetch === 1'b1) last_vec <= {16'h0000, vec_addr};
    if (status_load === 1'b1) last_st <= {24'h00_0000, status_out};
    cyc++;
    // no sequence here needs more than a few thousand cycles
    if (cyc == 20000) begin
      n_mismatch++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= 32'(a);
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    bus(a, 1'b0, 32'h0000_0000);
    chk(rd, {16'h0000, e});
  endtask
  // one instruction end, then long enough for any whole sequence
  task automatic fire();
    instr_last <= 1'b1;
    // hold the instruction end until a machine-cycle edge takes it
    do @(posedge hclk); while (mc_en !== 1'b1);
    {instr_last, opcode_undefined, ret_mask, ret_nonmask} <= 4'h0;
    opcode <= 8'h00;
    seen = 32'h0000_0000;
    repeat (60) begin
      @(posedge hclk);
      if (seq_busy === 1'b1) seen = 32'h0000_0001;
    end
  endtask
  task automatic pulse(input logic [15:0] m);
    irq_req <= m;
    @(posedge hclk);
    irq_req <= 16'h0000;
  endtask
  task automatic acc(input logic [15:0] v);
    fire();
    chk(seen, 32'h0000_0001);
    chk(last_vec, {16'h0000, v});
    chk(last_pc, {16'h0000, 8'h80, v[7:0]});
  endtask
  initial begin
    {hresetn, hsel, hwrite, instr_last, opcode_undefined, fetch_valid} = 6'h00;
    {ret_mask, ret_nonmask, htrans, opcode, irq_req, fetch_addr} = 44'h0;
    {haddr, hwdata} = 64'h0;
    hsize = 3'b010;
    pc_in = 16'h1234;
    status_in = 8'h5a;
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(8'h00, 16'h0000);
    rdc(8'h04, 16'h0000);
    rdc(8'h08, 16'h0000);
    rdc(8'h10, 16'h00ff);
    rdc(8'h40, 16'h0000);
    bus(8'h04, 1'b1, 32'h0000_0030);
    pulse(16'h0030);
    fire();
    chk(seen, 32'h0000_0000);
    rdc(8'h08, 16'h0030);
    bus(8'h00, 1'b1, 32'h0000_0001);
    acc(16'hfff6);
    rdc(8'h08, 16'h0020);
    bus(8'h04, 1'b1, 32'h0000_0020);
    rdc(8'h04, 16'h0020);
    rdc(8'h00, 16'h0000);
    rdc(8'h10, 16'h00fc);
    chk(32'(mdl.mem[8'hfd]), 32'h0000_0034);
    chk(32'(mdl.mem[8'hfe]), 32'h0000_0012);
    ret_mask <= 1'b1;
    fire();
    chk(last_pc, 32'h0000_1234);
    chk(last_st, 32'h0000_005b);
    rdc(8'h10, 16'h00ff);
    rdc(8'h00, 16'h0001);
    acc(16'hfff4);
    pulse(16'h0004);
    acc(16'hfffa);
    mdl.mem[8'hfa] <= 8'h00;
    mdl.mem[8'hfb] <= 8'h20;
    ret_nonmask <= 1'b1;
    fire();
    chk(last_pc, 32'h0000_2000);
    chk(last_st, 32'h0000_005a);
    pulse(16'h0008);
    acc(16'hfff8);
    opcode <= 8'hff;
    acc(16'hfffc);
    opcode_undefined <= 1'b1;
    acc(16'hfffc);
    rdc(8'h10, 16'h00f3);
    bus(8'h10, 1'b1, 32'h0000_00f6);
    rdc(8'h10, 16'h00f6);
    bus(8'h14, 1'b1, 32'h0000_0100);
    fetch_addr <= 16'h0040;
    fetch_valid <= 1'b1;
    repeat (2) @(posedge hclk);
    chk({31'h0, atrap_reset}, 32'h0000_0001);
    fetch_addr <= 16'h8000;
    repeat (2) @(posedge hclk);
    chk({31'h0, atrap_reset}, 32'h0000_0000);
    chk({24'h00_0000, fetch_fill}, 32'h0000_00ff);
    end_sim();
  end
endmodule // iars_sequencer_bench
